// >>> rtl/stc_cnt_if.sv
// signals between the control logic and the 16-bit counter core
`timescale 1ns/1ps
interface stc_cnt_if;
  logic run;
  logic on_rise;
  logic clr_on_a;
  logic clr_on_p;
  logic [15:0] cmpa;
  logic [7:0] cmpp;
  logic [15:0] count;
  logic a_match;
  logic p_match;
  modport ctl (output run, output on_rise, output clr_on_a, output clr_on_p,
    output cmpa, output cmpp, input count, input a_match, input p_match);
  modport cnt (input run, input on_rise, input clr_on_a, input clr_on_p,
    input cmpa, input cmpp, output count, output a_match, output p_match);
endinterface

// >>> rtl/stc_counter.sv
// 16-bit count-up core with comparator A and P and selectable clear
`timescale 1ns/1ps
module stc_counter (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // control side
  stc_cnt_if.cnt bus
);
  typedef struct packed {
    logic [15:0] count;
  } stc_cnt_state_t;

  stc_cnt_state_t state;
  stc_cnt_state_t next_state;

  // comparator P matches the count against its byte as top byte over a zero low byte; zero means run to full range
  assign bus.p_match = (bus.cmpp != stc_pkg::BYTE_RESET) &&
    (state.count == {bus.cmpp, stc_pkg::BYTE_RESET});
  // a zero compare A never matches, the counter just wraps
  assign bus.a_match = (bus.cmpa != stc_pkg::WORD_RESET) &&
    (state.count == bus.cmpa);
  assign bus.count = state.count;

  always_comb begin
    next_state = state;
    if (bus.on_rise) begin
      next_state.count = stc_pkg::WORD_RESET;
    end else if (bus.run) begin
      if ((bus.clr_on_a && bus.a_match) || (bus.clr_on_p && bus.p_match)) begin
        next_state.count = stc_pkg::WORD_RESET;
      end else begin
        // natural 16-bit wrap is the overflow clear
        next_state.count = state.count + stc_pkg::WORD_ONE;
      end
    end
    // not running: value frozen
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// >>> rtl/stc_pkg.sv
// constants shared by the timer output and clear control block
package stc_pkg;
  // ==========================================================
  // register indices on the plain register port
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_CMPP = 3'h6;
  // ==========================================================
  // control 0 field positions
  localparam int C0_PAUSE = 7;
  localparam int C0_ON = 3;
  // ==========================================================
  // control 1 field positions
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_PIN_HI = 5;
  localparam int C1_PIN_LO = 4;
  localparam int C1_LEVEL = 3;
  localparam int C1_INVERT = 2;
  localparam int C1_SWAP = 1;
  localparam int C1_CLR_SEL = 0;
  // ==========================================================
  // reset values and the count increment
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  // ==========================================================
  // operating modes and pin functions
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_UNDEF = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] PIN_F0 = 2'h0;
  localparam logic [1:0] PIN_F1 = 2'h1;
  localparam logic [1:0] PIN_F2 = 2'h2;
  localparam logic [1:0] PIN_F3 = 2'h3;
endpackage

// >>> rtl/stc_timer.sv
// timer output pin control, counter clear selection and counter readout
//
// Summary of operation
// - compare mode, A match: 00 keep, 01 low, 10 high, 11 toggle pin.
// - pwm mode: 00 inactive, 01 active, 10 pwm waveform, 11 single pulse.
// - compare match only visibly changes pin if requested level differs from initial.
// - counter-on rising edge returns the pin to its initial level.
// - compare mode: level bit gives initial pin level, 0 low, 1 high.
// - pwm mode: level bit gives active level, 0 low, 1 high.
// - single pulse: level bit is the pin level applied at counter-on rise.
// - invert bit inverts the output pin, except in timer/counter mode and the undefined mode.
// - swap bit 0: P sets period, A duty; 1: roles exchanged.
// - clear select 1 clears on A match, 0 on P match or overflow.
// - with clear select 0, overflow clear only when compare P is all zeros.
// - clear select ignored in pwm and single pulse modes.
// - counter readable as low and high byte, both zero after reset.
// - mode bits: 00 compare, 01 undefined, 10 pwm/pulse, 11 timer.
// - counter-on rise zeroes the counter, fall freezes it.
// - high byte read buffers low byte; next low read returns buffer.
`timescale 1ns/1ps
module stc_timer (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // timer output pin
  output logic TIMER_OUTPUT_PIN,
  output logic TIMER_OUTPUT_EN
);
  typedef struct packed {
    logic pause;
    logic counter_on;
    logic on_prev;
    logic [7:0] ctrl1;
    logic [15:0] cmpa;
    logic [7:0] cmpp;
    logic [7:0] lo_buf;
    logic [7:0] rdata;
    logic pin_level;
    logic pulse_active;
    logic pin_out;
    logic pin_en;
  } stc_state_t;

  stc_state_t state;
  stc_state_t next_state;
  stc_cnt_if cif ();

  logic [1:0] mode;
  logic [1:0] pin_fn;
  logic level_ctl;
  logic invert;
  logic swap;
  logic clr_sel;
  logic on_rise;
  logic run;
  logic [16:0] duty;
  logic pwm_active;
  logic raw_level;

  // ==========================================================
  // control field decode
  assign mode = {state.ctrl1[stc_pkg::C1_MODE_HI], state.ctrl1[stc_pkg::C1_MODE_LO]};
  assign pin_fn = {state.ctrl1[stc_pkg::C1_PIN_HI], state.ctrl1[stc_pkg::C1_PIN_LO]};
  assign level_ctl = state.ctrl1[stc_pkg::C1_LEVEL];
  assign invert = state.ctrl1[stc_pkg::C1_INVERT];
  assign swap = state.ctrl1[stc_pkg::C1_SWAP];
  assign clr_sel = state.ctrl1[stc_pkg::C1_CLR_SEL];
  assign on_rise = state.counter_on && !state.on_prev;
  assign run = state.counter_on && !state.pause;

  // ==========================================================
  // counter core
  assign cif.run = run;
  assign cif.on_rise = on_rise;
  assign cif.cmpa = state.cmpa;
  assign cif.cmpp = state.cmpp;

  always_comb begin
    if (mode == stc_pkg::MODE_PWM) begin
      // period comparator clears regardless of clear select
      cif.clr_on_a = swap;
      cif.clr_on_p = !swap;
    end else begin
      cif.clr_on_a = clr_sel;
      cif.clr_on_p = !clr_sel;
    end
  end

  stc_counter u_counter (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .bus(cif.cnt)
  );

  // ==========================================================
  // pwm duty: compare P zero stands for the full 65536 range
  always_comb begin
    if (swap) begin
      duty = (state.cmpp == stc_pkg::BYTE_RESET) ? 17'h10000 :
        {1'b0, state.cmpp, stc_pkg::BYTE_RESET};
    end else begin
      duty = {1'b0, state.cmpa};
    end
  end
  // duty above the period value simply never ends the active phase
  assign pwm_active = {1'b0, cif.count} < duty;

  // ==========================================================
  // pin level before inversion
  always_comb begin
    raw_level = state.pin_level;
    if (mode == stc_pkg::MODE_PWM) begin
      unique case (pin_fn)
        stc_pkg::PIN_F0: raw_level = !level_ctl;
        stc_pkg::PIN_F1: raw_level = level_ctl;
        stc_pkg::PIN_F2: raw_level = pwm_active ? level_ctl : !level_ctl;
        stc_pkg::PIN_F3: raw_level = state.pulse_active ? level_ctl : !level_ctl;
      endcase
    end
  end

  // ==========================================================
  // register file, pin state and readout
  always_comb begin
    next_state = state;
    next_state.on_prev = state.counter_on;
    next_state.rdata = stc_pkg::BYTE_RESET;
    if (WR) begin
      unique case (ADDR)
        stc_pkg::REG_CTRL0: begin
          next_state.pause = WDATA[stc_pkg::C0_PAUSE];
          next_state.counter_on = WDATA[stc_pkg::C0_ON];
        end
        stc_pkg::REG_CTRL1: next_state.ctrl1 = WDATA;
        stc_pkg::REG_CMPA_LO: next_state.cmpa[7:0] = WDATA;
        stc_pkg::REG_CMPA_HI: next_state.cmpa[15:8] = WDATA;
        stc_pkg::REG_CMPP: next_state.cmpp = WDATA;
        default: begin
        end
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        stc_pkg::REG_CTRL0: begin
          next_state.rdata[stc_pkg::C0_PAUSE] = state.pause;
          next_state.rdata[stc_pkg::C0_ON] = state.counter_on;
        end
        stc_pkg::REG_CTRL1: next_state.rdata = state.ctrl1;
        stc_pkg::REG_CNT_LO: next_state.rdata = state.lo_buf;
        stc_pkg::REG_CNT_HI: begin
          next_state.rdata = cif.count[15:8];
          next_state.lo_buf = cif.count[7:0];
        end
        stc_pkg::REG_CMPA_LO: next_state.rdata = state.cmpa[7:0];
        stc_pkg::REG_CMPA_HI: next_state.rdata = state.cmpa[15:8];
        stc_pkg::REG_CMPP: next_state.rdata = state.cmpp;
        default: begin
        end
      endcase
    end
    // pin events
    if (on_rise) begin
      next_state.pin_level = level_ctl;
      next_state.pulse_active = 1'b1;
    end else if (run && cif.a_match) begin
      // pulse ends on its duty compare
      if (mode == stc_pkg::MODE_PWM && cif.count == duty[15:0]) begin
        next_state.pulse_active = 1'b0;
      end
      if (mode == stc_pkg::MODE_COMPARE) begin
        // setting the level it already has leaves the pin unchanged
        unique case (pin_fn)
          stc_pkg::PIN_F0: next_state.pin_level = state.pin_level;
          stc_pkg::PIN_F1: next_state.pin_level = 1'b0;
          stc_pkg::PIN_F2: next_state.pin_level = 1'b1;
          stc_pkg::PIN_F3: next_state.pin_level = !state.pin_level;
        endcase
      end
    end else if (run && mode == stc_pkg::MODE_PWM && swap && cif.p_match) begin
      next_state.pulse_active = 1'b0;
    end
    // full-range duty: the pulse lasts the whole period
    if (run && mode == stc_pkg::MODE_PWM && swap && duty == 17'h10000 && cif.a_match) begin
      next_state.pulse_active = 1'b0;
    end
    // timer mode and the undefined code leave the pin undriven
    next_state.pin_en = (mode == stc_pkg::MODE_COMPARE) || (mode == stc_pkg::MODE_PWM);
    next_state.pin_out = next_state.pin_en ? (raw_level ^ invert) : 1'b0;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign RDATA = state.rdata;
  assign TIMER_OUTPUT_PIN = state.pin_out;
  assign TIMER_OUTPUT_EN = state.pin_en;
endmodule

// >>> testbench/stc_pin_monitor.sv
// external circuit on the timer pin: measures high and low widths
`timescale 1ns/1ps
module stc_pin_monitor (
  // clock and pin
  input wire logic mclk,
  input wire logic pin,
  input wire logic en,
  // last widths in clocks
  output int hi_w,
  output int lo_w
);
  logic last;
  int run;
  initial begin
    last = 1'b0;
    run = 0;
    hi_w = 0;
    lo_w = 0;
  end
  // a disabled pin floats, so it is not measured
  always @(posedge mclk) begin
    if (en === 1'b1 && pin !== last) begin
      if (last) hi_w = run;
      else lo_w = run;
      run = 1;
      last = pin;
    end else run = run + 1;
  end
endmodule

// >>> testbench/stc_timer_asserts.sv
// concurrent checks on the timer register port and output pin
`timescale 1ns/1ps
module stc_timer_asserts (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // output pin
  input wire logic TIMER_OUTPUT_PIN,
  input wire logic TIMER_OUTPUT_EN
);
  // ========================================
  // shadow controls; quiet counts clocks since any write
  logic [7:0] sh0;
  logic [7:0] sh1;
  logic [2:0] quiet;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sh0 <= 8'h00;
      sh1 <= 8'h00;
      quiet <= 3'h0;
    end else begin
      if (WR && ADDR == 3'h0) sh0 <= WDATA;
      if (WR && ADDR == 3'h1) sh1 <= WDATA;
      quiet <= WR ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
    end
  end
  // ========================================
  // properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_on_rise;
    WR && ADDR == 3'h0 && WDATA[3] && !sh0[3] && sh1[7:6] == 2'h0;
  endsequence
  sequence s_settled;
    quiet == 3'h7 && !WR;
  endsequence
  AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  AST_RD_UNMAPPED: assert property (RD && ADDR == 3'h7 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL1_RD: assert property (RD && ADDR == 3'h1 |=> RDATA == $past(sh1))
    else $error("control 1 readback wrong");
  AST_CTRL0_RD: assert property (RD && ADDR == 3'h0 |=> RDATA == ($past(sh0) & 8'h88))
    else $error("control 0 readback wrong");
  AST_ON_LEVEL: assert property (s_on_rise |-> ##[2:4] TIMER_OUTPUT_PIN == (sh1[3] ^ sh1[2]))
    else $error("pin not at initial level after start");
  AST_EN_LOW: assert property (!TIMER_OUTPUT_EN |-> !TIMER_OUTPUT_PIN)
    else $error("pin high while not enabled");
  AST_TIMER_OFF: assert property (s_settled and (sh1[7:6] == 2'h3) |-> !TIMER_OUTPUT_EN)
    else $error("pin enabled in timer mode");
  AST_CMP_EN: assert property (s_settled and (sh1[7:6] == 2'h0) |-> TIMER_OUTPUT_EN)
    else $error("pin not enabled in compare mode");
  AST_CMP_KEEP: assert property (s_settled and (sh1[7:4] == 4'h0) |=> $stable(TIMER_OUTPUT_PIN))
    else $error("pin moved with no-change function");
  AST_PWM_FORCE: assert property (s_settled and (sh0[3] && sh1[7:5] == 3'h4) |->
    TIMER_OUTPUT_PIN == ((sh1[4] ~^ sh1[3]) ^ sh1[2]))
    else $error("forced pwm level wrong");
endmodule

// >>> testbench/stc_timer_tb_top.sv
// self-checking bench for the timer output and clear control block
`timescale 1ns/1ps
module stc_timer_tb_top;
  logic MCLK;
  logic RST_N;
  logic [2:0] ADDR;
  logic [7:0] WDATA;
  logic WR;
  logic RD;
  logic [7:0] RDATA;
  logic TIMER_OUTPUT_PIN;
  logic TIMER_OUTPUT_EN;
  logic [7:0] d;
  logic [15:0] v1;
  logic [15:0] v2;
  int fail_count;
  int compares;
  int cyc;
  int t_rd;
  int t1;
  int n;
  int e;
  int hi_w;
  int lo_w;
  bit inv;
  logic [7:0] exp_q[$];
  stc_timer stc_timer_i (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
    .TIMER_OUTPUT_EN(TIMER_OUTPUT_EN));
  stc_pin_monitor stc_pin_monitor_i (.mclk(MCLK), .pin(TIMER_OUTPUT_PIN),
    .en(TIMER_OUTPUT_EN), .hi_w(hi_w), .lo_w(lo_w));
  // ========================================
  // bus cycles and comparison
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    d = RDATA;
    t_rd = cyc;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pin_at(input int c, input logic x);
    repeat (c) @(posedge MCLK);
    @(negedge MCLK);
    chk(TIMER_OUTPUT_PIN, x);
  endtask
  // high byte first so the low byte comes from the buffer
  task automatic rd16(output logic [15:0] v, output int t);
    rd(3'h3);
    v[15:8] = d;
    t = t_rd;
    rd(3'h2);
    v[7:0] = d;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ========================================
  // clock and hang guard
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ========================================
  // tests
  initial begin
    {RST_N, WR, RD, ADDR, WDATA, fail_count, compares, cyc} = '0;
    n = $urandom(32'hA2A4AC19);
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      chk(d, 0);
    end
    for (int i = 0; i < 4; i++) begin
      e = $urandom;
      // model: control 1 reads back whole, control 0 only pause and on
      exp_q.push_back(e[7:0]);
      exp_q.push_back(e[7:0] & 8'h80);
      wr(3'h1, e[7:0]);
      rd(3'h1);
      chk(d, exp_q.pop_front());
      wr(3'h0, e[7:0] & 8'hF7);
      rd(3'h0);
      chk(d, exp_q.pop_front());
      wr(3'h7, e[7:0]);
      rd(3'h7);
      chk(d, 0);
      wr(3'h3, e[7:0]);
      rd(3'h3);
      chk(d, 0);
    end
    $display("end of test: registers");
    n = 10 + $urandom % 20;
    wr(3'h0, 8'h00);
    wr(3'h4, n[7:0]);
    wr(3'h5, 8'h00);
    for (int k = 0; k < 8; k++) begin
      inv = $urandom % 2;
      wr(3'h0, 8'h00);
      wr(3'h1, {2'h0, k[2:0], inv, 2'h1});
      wr(3'h0, 8'h08);
      pin_at(5, k[0] ^ inv);
      e = (k[2:1] == 0) ? k[0] : (k[2:1] == 3) ? !k[0] : k[2];
      pin_at(n, e[0] ^ inv);
    end
    repeat (3 * n + 3) @(posedge MCLK);
    chk(hi_w, n + 1);
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h1, 8'h30);
    wr(3'h0, 8'h08);
    repeat (800) @(posedge MCLK);
    chk(hi_w, 257);
    $display("end of test: compare mode");
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h40);
    wr(3'h1, 8'hA8);
    wr(3'h0, 8'h08);
    repeat (800) @(posedge MCLK);
    chk(hi_w, 64);
    chk(lo_w, 193);
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h90);
    wr(3'h5, 8'h01);
    wr(3'h1, 8'hA3);
    wr(3'h0, 8'h08);
    repeat (1300) @(posedge MCLK);
    chk(lo_w, 256);
    chk(hi_w, 145);
    for (int k = 0; k < 4; k++) begin
      inv = $urandom % 2;
      wr(3'h0, 8'h00);
      wr(3'h1, {3'h4, k[1:0], inv, 2'h0});
      wr(3'h0, 8'h08);
      pin_at(10, !(k[0] ^ k[1]) ^ inv);
    end
    // single pulse, duty 32 from compare A, period from compare P
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h20);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'hB8);
    // first start flushes a stale pulse; the second one starts from idle
    wr(3'h0, 8'h08);
    repeat (60) @(posedge MCLK);
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h08);
    repeat (60) @(posedge MCLK);
    chk(hi_w, 33);
    $display("end of test: pwm mode");
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'hC0);
    wr(3'h0, 8'h08);
    pin_at(20, 1'b0);
    chk(TIMER_OUTPUT_EN, 0);
    rd16(v1, t1);
    repeat (10) @(posedge MCLK);
    rd16(v2, e);
    chk(v2 - v1, e - t1);
    wr(3'h0, 8'h00);
    rd16(v1, t1);
    repeat (5) @(posedge MCLK);
    rd16(v2, e);
    chk(v2, v1);
    rd(3'h2);
    chk(d, v1[7:0]);
    wr(3'h0, 8'h08);
    rd16(v1, t1);
    chk(v1 < 16'h0010, 1);
    $display("end of test: counter");
    end_of_test();
  end
endmodule
bind stc_timer stc_timer_asserts stc_timer_asserts_i (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
  .TIMER_OUTPUT_EN(TIMER_OUTPUT_EN));
